/* hdl/ehg_map.vh */
`ifndef EHG_MAP_VH
`define EHG_MAP_VH

// dictionary indices
`define EHG_IDX_DEVTYPE 16'h1000
`define EHG_IDX_ERRFLAG 16'h1001
`define EHG_IDX_VENDOR 16'h1002
`define EHG_IDX_HISTORY 16'h1003
`define EHG_IDX_GUARD 16'h100C
`define EHG_IDX_LIFEMUL 16'h100D

// reset values
`define EHG_GUARD_RST 16'h0000
`define EHG_LIFEMUL_RST 8'h00

// field positions
`define EHG_GENERIC_BIT 0
`define EHG_CODE_LSB 0
`define EHG_SRC_LSB 16
`define EHG_DESC_LSB 24

// function block flags in the additional-information field
`define EHG_FB_DI 16'h0001
`define EHG_FB_AI 16'h0002
`define EHG_FB_LUT 16'h2000
`define EHG_FB_LOGIC 16'h4000
`define EHG_FB_MISC 16'h8000

// history entry codes
`define EHG_CODE_OVR_HIGH 32'h2001F001
`define EHG_CODE_OVR_LOW 32'h4001F001
`define EHG_CODE_RX_TMO 32'h00008100
`define EHG_CODE_LIFEGUARD 32'h10008130
`define EHG_DESC_HEARTBEAT 8'h80
`define EHG_GUARD_ERROR 16'h8130

// list geometry
`define EHG_HIST_DEPTH 4

// timing: guard unit is one millisecond
`define EHG_MS_NS 1000000
`define EHG_CLK_NS 50
`define EHG_MS_CYCLES (`EHG_MS_NS / `EHG_CLK_NS)

`endif

/* hdl/ehg_error_guard.v */
// Functional notes
// - bit 0 set while any error active
// - new error inserted at head, sub0 count
// - entry removed when its error clears
// - count zero when no error active
// - writing zero to count empties list
// - emptying list keeps error flag set
// - four entries max, oldest dropped
// - entry is description, source byte, code
// - lifeguard event logs 10008130h
// - heartbeat loss logs 80, node, 8130h
// - overload logs 2001F001h or 4001F001h
// - receive timeout flagged, logs 00008100h
// - guard time in ms, zero disables
// - lifetime is factor times guard time
// - never life guarding with heartbeat monitoring
// - device-type word read-only, two fields
// - one flag bit per function block
// - zero life time factor disables guarding
`timescale 1ns/1ps
`include "ehg_map.vh"

module ehg_error_guard #(
  parameter MS_CYCLES = `EHG_MS_CYCLES,
  parameter [15:0] GENERAL_PROFILE = 16'h0000, // arbitrary value
  parameter HAS_DI = 1,
  parameter HAS_AI = 1,
  parameter HAS_LUT = 1,
  parameter HAS_LOGIC = 1,
  parameter HAS_MISC = 1
) (
  input wire ref_clk,
  input wire rst_n,
  input wire odReq,
  input wire odWrite,
  input wire [15:0] odIndex,
  input wire [7:0] odSub,
  input wire [31:0] odWrData,
  output reg [31:0] odRdData,
  output reg odDone,
  output reg odAbort,
  input wire faultHigh,
  input wire faultLow,
  input wire rxTimeout,
  input wire hbLost,
  input wire [7:0] hbNode,
  input wire hbMonEnable,
  input wire guardRx,
  output reg genericError,
  output reg rxTimeoutFlag,
  output reg lifeGuardActive,
  output reg lifeGuardFault
);

  localparam NSRC = 5;
  localparam [2:0] SRC_HIGH = 3'h0;
  localparam [2:0] SRC_LOW = 3'h1;
  localparam [2:0] SRC_RXTMO = 3'h2;
  localparam [2:0] SRC_LIFE = 3'h3;
  localparam [2:0] SRC_HB = 3'h4;
  localparam [2:0] SRC_NONE = 3'h7;
  localparam DEPTH = `EHG_HIST_DEPTH;

  // ----------------------------------------------------------------
  // device-type word
  // ----------------------------------------------------------------
  wire [15:0] addInfo;
  assign addInfo = (HAS_DI ? `EHG_FB_DI : 16'h0000) | (HAS_AI ? `EHG_FB_AI : 16'h0000) |
                   (HAS_LUT ? `EHG_FB_LUT : 16'h0000) | (HAS_LOGIC ? `EHG_FB_LOGIC : 16'h0000) |
                   (HAS_MISC ? `EHG_FB_MISC : 16'h0000);
  wire [31:0] devTypeWord;
  assign devTypeWord = {addInfo, GENERAL_PROFILE};

  // ----------------------------------------------------------------
  // guard configuration and lifetime watch
  // ----------------------------------------------------------------
  reg [15:0] guard_reg;
  reg [7:0] lifeMul_reg;
  reg [14:0] msCnt_reg;
  reg msTick_reg;
  reg [23:0] lifeCnt_reg;
  reg armed_reg;
  reg lifeFault_reg;
  wire [23:0] lifetime;
  wire guardOn;

  assign lifetime = guard_reg * lifeMul_reg;
  // heartbeat monitoring takes precedence over life guarding
  assign guardOn = (guard_reg != 16'h0000) && (lifeMul_reg != 8'h00) && !hbMonEnable;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      msCnt_reg <= 15'h0000;
      msTick_reg <= 1'b0;
    end else if (msCnt_reg == MS_CYCLES - 1) begin
      msCnt_reg <= 15'h0000;
      msTick_reg <= 1'b1;
    end else begin
      msCnt_reg <= msCnt_reg + 15'h0001;
      msTick_reg <= 1'b0;
    end
  end

  // watch starts at the first guard request, as the manager drives it
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      lifeCnt_reg <= 24'h000000;
      armed_reg <= 1'b0;
      lifeFault_reg <= 1'b0;
    end else if (!guardOn) begin
      lifeCnt_reg <= 24'h000000;
      armed_reg <= 1'b0;
      lifeFault_reg <= 1'b0;
    end else if (guardRx) begin
      lifeCnt_reg <= 24'h000000;
      armed_reg <= 1'b1;
      lifeFault_reg <= 1'b0;
    end else if (armed_reg && msTick_reg && !lifeFault_reg) begin
      if (lifeCnt_reg + 24'h000001 >= lifetime) begin
        lifeFault_reg <= 1'b1;
      end
      lifeCnt_reg <= lifeCnt_reg + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // error sources
  // ----------------------------------------------------------------
  wire [NSRC-1:0] active;
  assign active = {hbLost, lifeFault_reg, rxTimeout, faultLow, faultHigh};
  reg [NSRC-1:0] tracked_reg;

  function [31:0] codeOf;
    input [2:0] src;
    input [7:0] node;
    begin
      case (src)
        SRC_HIGH: codeOf = `EHG_CODE_OVR_HIGH;
        SRC_LOW: codeOf = `EHG_CODE_OVR_LOW;
        SRC_RXTMO: codeOf = `EHG_CODE_RX_TMO;
        SRC_LIFE: codeOf = `EHG_CODE_LIFEGUARD;
        SRC_HB: codeOf = {`EHG_DESC_HEARTBEAT, node, `EHG_GUARD_ERROR};
        default: codeOf = 32'h00000000;
      endcase
    end
  endfunction

  // one source change handled per cycle; the rest wait their turn
  reg [2:0] pickSrc;
  reg pickRise;
  integer s;
  always @* begin
    pickSrc = SRC_NONE;
    pickRise = 1'b0;
    for (s = NSRC - 1; s >= 0; s = s - 1) begin
      if (active[s] != tracked_reg[s]) begin
        pickSrc = s[2:0];
        pickRise = active[s];
      end
    end
  end

  // ----------------------------------------------------------------
  // history list
  // ----------------------------------------------------------------
  reg [31:0] entry_reg [0:DEPTH-1];
  reg [2:0] tag_reg [0:DEPTH-1];
  reg [2:0] count_reg;
  reg [31:0] entry_next [0:DEPTH-1];
  reg [2:0] tag_next [0:DEPTH-1];
  reg [2:0] count_next;
  reg hit;
  reg clearList;
  integer i;

  always @* begin
    hit = 1'b0;
    count_next = count_reg;
    for (i = 0; i < DEPTH; i = i + 1) begin
      entry_next[i] = entry_reg[i];
      tag_next[i] = tag_reg[i];
    end
    if (clearList) begin
      count_next = 3'h0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        entry_next[i] = 32'h00000000;
        tag_next[i] = SRC_NONE;
      end
    end else if (pickSrc != SRC_NONE && pickRise) begin
      for (i = DEPTH - 1; i > 0; i = i - 1) begin
        entry_next[i] = entry_reg[i-1];
        tag_next[i] = tag_reg[i-1];
      end
      entry_next[0] = codeOf(pickSrc, hbNode);
      tag_next[0] = pickSrc;
      if (count_reg < DEPTH) begin
        count_next = count_reg + 3'h1;
      end
    end else if (pickSrc != SRC_NONE) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (tag_reg[i] == pickSrc && i < count_reg) begin
          hit = 1'b1;
        end
        if (hit) begin
          entry_next[i] = (i < DEPTH - 1) ? entry_reg[(i + 1) % DEPTH] : 32'h00000000;
          tag_next[i] = (i < DEPTH - 1) ? tag_reg[(i + 1) % DEPTH] : SRC_NONE;
        end
      end
      if (hit) begin
        count_next = count_reg - 3'h1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      count_reg <= 3'h0;
      tracked_reg <= {NSRC{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        entry_reg[i] <= 32'h00000000;
        tag_reg[i] <= SRC_NONE;
      end
    end else begin
      count_reg <= count_next;
      for (i = 0; i < DEPTH; i = i + 1) begin
        entry_reg[i] <= entry_next[i];
        tag_reg[i] <= tag_next[i];
      end
      // a clear empties the list but the source stays known as active
      if (pickSrc != SRC_NONE) begin
        tracked_reg[pickSrc] <= pickRise;
      end
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      genericError <= 1'b0;
      rxTimeoutFlag <= 1'b0;
      lifeGuardActive <= 1'b0;
      lifeGuardFault <= 1'b0;
    end else begin
      genericError <= |active;
      rxTimeoutFlag <= rxTimeout;
      lifeGuardActive <= guardOn;
      lifeGuardFault <= lifeFault_reg;
    end
  end

  // ----------------------------------------------------------------
  // dictionary access
  // ----------------------------------------------------------------
  reg [31:0] rdMux;
  reg accOk;
  reg wrGuard;
  reg wrLife;
  wire subZero;
  assign subZero = (odSub == 8'h00);

  always @* begin
    rdMux = 32'h00000000;
    accOk = 1'b0;
    wrGuard = 1'b0;
    wrLife = 1'b0;
    clearList = 1'b0;
    case (odIndex)
      `EHG_IDX_DEVTYPE: begin
        accOk = subZero && !odWrite;
        rdMux = devTypeWord;
      end
      `EHG_IDX_ERRFLAG: begin
        accOk = subZero && !odWrite;
        rdMux = {31'h00000000, genericError};
      end
      `EHG_IDX_VENDOR: begin
        accOk = subZero && !odWrite;
        rdMux = {8'h00, 3'h0, tracked_reg, 5'h00, lifeFault_reg, armed_reg, guardOn, 5'h00, count_reg};
      end
      `EHG_IDX_HISTORY: begin
        if (subZero) begin
          accOk = !odWrite || (odWrData == 32'h00000000);
          clearList = odReq && odWrite && (odWrData == 32'h00000000);
          rdMux = {29'h00000000, count_reg};
        end else if (odSub <= DEPTH) begin
          accOk = !odWrite;
          rdMux = (odSub <= count_reg) ? entry_reg[odSub[1:0] - 2'h1] : 32'h00000000;
        end
      end
      `EHG_IDX_GUARD: begin
        accOk = subZero;
        wrGuard = subZero && odWrite && odReq;
        rdMux = {16'h0000, guard_reg};
      end
      `EHG_IDX_LIFEMUL: begin
        accOk = subZero;
        wrLife = subZero && odWrite && odReq;
        rdMux = {24'h000000, lifeMul_reg};
      end
      default: begin
        accOk = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      guard_reg <= `EHG_GUARD_RST;
      lifeMul_reg <= `EHG_LIFEMUL_RST;
      odRdData <= 32'h00000000;
      odDone <= 1'b0;
      odAbort <= 1'b0;
    end else begin
      if (wrGuard) begin
        guard_reg <= odWrData[15:0];
      end
      if (wrLife) begin
        lifeMul_reg <= odWrData[7:0];
      end
      odDone <= odReq && accOk;
      odAbort <= odReq && !accOk;
      if (odReq && accOk && !odWrite) begin
        odRdData <= rdMux;
      end
    end
  end

endmodule

/* bench/ehg_error_guard_properties.sv */
`timescale 1ns/1ps
module ehg_checker (
  input wire ref_clk,
  input wire rst_n,
  input wire odReq,
  input wire odWrite,
  input wire [15:0] odIndex,
  input wire [7:0] odSub,
  input wire [31:0] odWrData,
  input wire odDone,
  input wire odAbort,
  input wire faultHigh,
  input wire rxTimeout,
  input wire hbMonEnable,
  input wire genericError,
  input wire rxTimeoutFlag,
  input wire lifeGuardActive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire wrHist = odReq && odWrite && odIndex == 16'h1003;
  wire wrGuard = odReq && odWrite && odIndex == 16'h100C && odSub == 8'h00;
  ack_once_a: assert property (odReq |=> odDone != odAbort) else $error("access not answered once");
  no_spur_a: assert property (!odReq |=> !odDone && !odAbort) else $error("answer without request");
  flag_on_a: assert property (faultHigh |=> genericError) else $error("error flag missing");
  rx_flag_a: assert property ($rose(rxTimeout) |=> rxTimeoutFlag) else $error("rx timeout not flagged");
  hb_excl_a: assert property (hbMonEnable |=> !lifeGuardActive) else $error("guarding with heartbeat");
  ro_obj_a: assert property (odReq && odWrite && odIndex >= 16'h1000 && odIndex <= 16'h1002 |=> odAbort)
    else $error("read-only write taken");
  hist_ro_a: assert property (wrHist && odSub != 8'h00 |=> odAbort) else $error("entry write taken");
  clr_ok_a: assert property (wrHist && odSub == 8'h00 && odWrData == 32'h0 |=> odDone)
    else $error("clear refused");
  guard_off_a: assert property (wrGuard && odWrData[15:0] == 16'h0000 |=> ##[1:2] !lifeGuardActive)
    else $error("zero guard still active");
endmodule
bind ehg_error_guard ehg_checker chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .odReq(odReq), .odWrite(odWrite),
  .odIndex(odIndex), .odSub(odSub), .odWrData(odWrData), .odDone(odDone), .odAbort(odAbort),
  .faultHigh(faultHigh), .rxTimeout(rxTimeout), .hbMonEnable(hbMonEnable), .genericError(genericError),
  .rxTimeoutFlag(rxTimeoutFlag), .lifeGuardActive(lifeGuardActive));

/* bench/ehg_manager.sv */
`timescale 1ns/1ps
module ehg_manager (
  input wire ref_clk,
  output reg odReq,
  output reg odWrite,
  output reg [15:0] odIndex,
  output reg [7:0] odSub,
  output reg [31:0] odWrData,
  input wire [31:0] odRdData,
  input wire odDone,
  input wire odAbort
);
  initial begin
    odReq = 1'b0;
    odWrite = 1'b0;
    odIndex = 16'h0000;
    odSub = 8'h00;
    odWrData = 32'h00000000;
  end
  // request stands for its taking edge only; the registered answer is taken just after that edge,
  // because holding the request any longer would start a second access
  task access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
    output logic [31:0] rd, output logic [1:0] rs);
    @(posedge ref_clk) #1;
    odReq = 1'b1;
    odWrite = wr;
    odIndex = idx;
    odSub = sub;
    odWrData = wd;
    @(posedge ref_clk) #1;
    rd = odRdData;
    rs = {odAbort, odDone};
    odReq = 1'b0;
    // released lines flip so a stale copy is never mistaken for data
    odWrite = ~odWrite;
    odIndex = ~odIndex;
    odSub = ~odSub;
    odWrData = ~odWrData;
  endtask
endmodule

/* bench/ehg_error_guard_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin errTotal++; \
  $display("mismatch at %0t: %h not %h", $time, g, e); end end
module ehg_error_guard_tb_top;
  reg refClk, rstN, faultHigh, faultLow, rxTimeout, hbLost, hbMonEnable, guardRx;
  reg [7:0] hbNode;
  wire odReq, odWrite, odDone, odAbort, genericError, rxTimeoutFlag, lifeGuardActive, lifeGuardFault;
  wire [15:0] odIndex;
  wire [7:0] odSub;
  wire [31:0] odWrData, odRdData;
  logic [31:0] rd, v;
  logic [1:0] rs;
  bit [31:0] q[$];
  int errTotal = 0, checkCount = 0, k, n;
  ehg_error_guard #(.MS_CYCLES(4)) dut_u (.ref_clk(refClk), .rst_n(rstN), .odReq(odReq), .odWrite(odWrite),
    .odIndex(odIndex), .odSub(odSub), .odWrData(odWrData), .odRdData(odRdData), .odDone(odDone),
    .odAbort(odAbort), .faultHigh(faultHigh), .faultLow(faultLow), .rxTimeout(rxTimeout), .hbLost(hbLost),
    .hbNode(hbNode), .hbMonEnable(hbMonEnable), .guardRx(guardRx), .genericError(genericError),
    .rxTimeoutFlag(rxTimeoutFlag), .lifeGuardActive(lifeGuardActive), .lifeGuardFault(lifeGuardFault));
  ehg_manager mgr_u (.ref_clk(refClk), .odReq(odReq), .odWrite(odWrite), .odIndex(odIndex), .odSub(odSub),
    .odWrData(odWrData), .odRdData(odRdData), .odDone(odDone), .odAbort(odAbort));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    refClk = 1'b0;
    forever #25 refClk = ~refClk;
  end
  task acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
    mgr_u.access(wr, idx, sub, wd, rd, rs);
  endtask
  task step(input int c);
    repeat (c) @(posedge refClk);
    #1;
  endtask
  task chk_list;
    int i;
    acc(0, 16'h1003, 0, 0);
    `CHK(rd, 32'(q.size()))
    for (i = 1; i <= 4; i++) begin
      acc(0, 16'h1003, i[7:0], 0);
      `CHK(rd, (i <= q.size()) ? q[i-1] : 32'h0)
    end
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1000000;
    errTotal++;
    report_and_stop;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstN, faultHigh, faultLow, rxTimeout, hbLost, hbMonEnable, guardRx} = 7'h00;
    hbNode = 8'h00;
    void'($urandom(24));
    step(4);
    rstN = 1'b1;
    acc(0, 16'h1000, 0, 0);
    `CHK(rd, {16'h0001 | 16'h0002 | 16'h2000 | 16'h4000 | 16'h8000, 16'h0000})
    acc(1, 16'h1000, 0, 0);
    `CHK(rs, 2'b10)
    acc(0, 16'h1001, 0, 0);
    `CHK(rd, 32'h0)
    acc(0, 16'h1234, 0, 0);
    `CHK(rs, 2'b10)
    chk_list;
    done("reset");
    v = $urandom;
    acc(1, 16'h100C, 0, v);
    acc(0, 16'h100C, 0, 0);
    `CHK(rd, {16'h0, v[15:0]})
    acc(1, 16'h100D, 0, v);
    acc(0, 16'h100D, 0, 0);
    `CHK(rd, {24'h0, v[7:0]})
    acc(1, 16'h100C, 0, 0);
    step(3);
    `CHK(lifeGuardActive, 1'b0)
    acc(1, 16'h100C, 0, 3);
    acc(1, 16'h100D, 0, 3);
    step(3);
    `CHK(lifeGuardActive, 1'b1)
    done("guard");
    hbNode = $urandom;
    for (k = 0; k < 4; k++) begin
      {hbLost, rxTimeout, faultLow, faultHigh} = (4'h2 << k) - 4'h1;
      q.push_front(k == 0 ? 32'h2001F001 : k == 1 ? 32'h4001F001 : k == 2 ? 32'h00008100 : {8'h80, hbNode, 16'h8130});
      step(3);
      chk_list;
    end
    `CHK(rxTimeoutFlag, 1'b1)
    guardRx = 1'b1;
    step(1);
    guardRx = 1'b0;
    for (n = 0; n < 100 && lifeGuardFault !== 1'b1; n++)
      step(1);
    if (n == 100) begin
      errTotal++;
      report_and_stop;
    end
    // nine ms at four cycles each; a sum of the two would land near 24
    `CHK(n >= 28 && n <= 42, 1'b1)
    q.push_front(32'h10008130);
    q = q[0:3];
    step(2);
    chk_list;
    rxTimeout = 1'b0;
    q.delete(2);
    step(3);
    chk_list;
    done("history");
    acc(1, 16'h1003, 0, 1);
    `CHK(rs, 2'b10)
    acc(1, 16'h1003, 1, 0);
    `CHK(rs, 2'b10)
    acc(0, 16'h1003, 5, 0);
    `CHK(rs, 2'b10)
    acc(1, 16'h1003, 0, 0);
    `CHK(rs, 2'b01)
    q.delete();
    chk_list;
    acc(0, 16'h1001, 0, 0);
    `CHK(rd, 32'h1)
    {faultHigh, faultLow, hbLost, hbMonEnable} = 4'h1;
    step(4);
    `CHK(lifeGuardActive, 1'b0)
    `CHK(genericError, 1'b0)
    chk_list;
    done("clear");
    report_and_stop;
  end
endmodule
